/* hw/atapr_pkg.sv */
package atapr_pkg;
  // register bus geometry
  localparam int ADDR_W = 10;            // byte address width
  localparam int IDX_W  = ADDR_W - 2;    // word index width
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // register indices, byte address is four times these
  localparam logic [IDX_W-1:0] IDX_ATTACK   = 8'h69; // right attack time
  localparam logic [IDX_W-1:0] IDX_DECAY    = 8'h6A; // right decay time
  localparam logic [IDX_W-1:0] IDX_PATH     = 8'h6B; // adc path, bus cond
  localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 8'h70; // sticky events
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 8'h71; // event enables
  localparam logic [IDX_W-1:0] IDX_EFF_TIME = 8'h72; // applied times
  localparam logic [7:0] REG_RESET = 8'h00;
  // time register fields
  localparam int SRC_BIT = 7;
  localparam int BASE_HI = 6;
  localparam int BASE_LO = 5;
  localparam int MULT_HI = 4;
  localparam int MULT_LO = 2;
  // path register fields
  localparam int HPF_L_BIT  = 7;
  localparam int HPF_R_BIT  = 6;
  localparam int MIC_L_BIT  = 5;          // 1: left analog
  localparam int MIC_R_BIT  = 4;          // 1: right analog
  localparam int PFILT_BIT  = 3;
  localparam int BUSDIS_BIT = 2;
  localparam int BUSERR_BIT = 0;
  localparam logic [7:0] PATH_WMASK = 8'hFC; // d1 and d0 not writable
  // interrupt bits
  localparam int IRQ_W      = 2;
  localparam int IRQ_BUSERR = 0;
  localparam int IRQ_CAP    = 1;
  // times in milliseconds
  localparam int TIME_W  = 16;
  localparam int RATIO_W = 4;             // code 0 = ratio 1, step 0.5
  typedef logic [TIME_W-1:0] atapr_ms_t;
  // 7, 8, 10, 11 ms
  localparam atapr_ms_t ATTACK_BASE_MS [4] = '{
    16'h0007, 16'h0008, 16'h000A, 16'h000B};
  // 50, 150, 250, 350 ms
  localparam atapr_ms_t DECAY_BASE_MS [4] = '{
    16'h0032, 16'h0096, 16'h00FA, 16'h015E};
  // attack needs no cap, 11 ms * 128 stays below this
  localparam atapr_ms_t NO_CAP_MS = 16'hFFFF;
  // decay caps per ratio code: 4, 5.6, 8, 9.6, 11.2 (x2), 16 (x2),
  // 19.2, 22.4 (x2) seconds; unused codes keep the largest cap
  localparam atapr_ms_t DECAY_CAP_MS [16] = '{
    16'h0FA0, 16'h15E0, 16'h1F40, 16'h2580, 16'h2BC0, 16'h2BC0,
    16'h3E80, 16'h3E80, 16'h4B00, 16'h5780, 16'h5780, 16'h5780,
    16'h5780, 16'h5780, 16'h5780, 16'h5780};
  // applied gain control times
  typedef struct packed {
    atapr_ms_t attackMs;
    atapr_ms_t decayMs;
  } atapr_agc_s;
  // record path steering
  typedef struct packed {
    logic hpfProgLeft;
    logic hpfProgRight;
    logic micAnalogLeft;
    logic micAnalogRight;
    logic progFilterOn;
    logic busDetectOn;
  } atapr_path_s;
endpackage : atapr_pkg

/* hw/atapr_time_calc.sv */
`timescale 1ns/10ps
module atapr_time_calc #(
  parameter atapr_pkg::atapr_ms_t BASE_MS [4] = atapr_pkg::ATTACK_BASE_MS
) (
  input  logic                 useOwn,
  input  logic [1:0]           baseCode,
  input  logic [2:0]           multCode,
  input  atapr_pkg::atapr_ms_t legacyMs,
  input  atapr_pkg::atapr_ms_t capMs,
  output atapr_pkg::atapr_ms_t timeMs,
  output logic                 capped
);
  // baseline times a power of two; 350 ms * 128 still fits 16 bits
  wire atapr_pkg::atapr_ms_t scaledMs = BASE_MS[baseCode] << multCode;
  // choose own fields or the older register's time
  wire atapr_pkg::atapr_ms_t rawMs = useOwn ? scaledMs : legacyMs;
  // the limit applies to whichever source is active
  assign capped = rawMs > capMs;
  assign timeMs = capped ? capMs : rawMs;
endmodule : atapr_time_calc

/* hw/atapr_regs.sv */
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module atapr_regs (
  input  logic                               clk,
  input  logic                               rst,
  // axi4-lite slave
  input  logic [atapr_pkg::ADDR_W-1:0]       s_axi_awaddr,
  input  logic                               s_axi_awvalid,
  output logic                               s_axi_awready,
  input  logic [31:0]                        s_axi_wdata,
  input  logic [3:0]                         s_axi_wstrb,
  input  logic                               s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  logic                               s_axi_bready,
  input  logic [atapr_pkg::ADDR_W-1:0]       s_axi_araddr,
  input  logic                               s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [31:0]                        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  logic                               s_axi_rready,
  // gain control side
  input  atapr_pkg::atapr_ms_t               legacyAttackMs,
  input  atapr_pkg::atapr_ms_t               legacyDecayMs,
  input  logic [atapr_pkg::RATIO_W-1:0]      adcDecimationRatio,
  input  logic                               dacsPoweredDown,
  input  logic                               busErrorSeen,
  output atapr_pkg::atapr_agc_s              agcTimes,
  output atapr_pkg::atapr_path_s             pathCtrl,
  output logic                               busErrRecover,
  output logic                               irq
);
  // stored register contents
  logic [7:0]                  attack_reg;      // right attack time
  logic [7:0]                  decay_reg;       // right decay time
  logic [7:0]                  path_reg;        // d7..d2 stored here
  logic                        busErr_reg;      // d0 status
  logic [atapr_pkg::IRQ_W-1:0] irqStat_reg;     // sticky events
  logic [atapr_pkg::IRQ_W-1:0] irqMask_reg;     // event enables
  logic                        capPrev_reg;     // cap edge detector
  // bus handshake state
  logic                        awready_reg;
  logic                        wready_reg;
  logic                        bvalid_reg;
  logic [1:0]                  bresp_reg;
  logic                        arready_reg;
  logic                        rvalid_reg;
  logic [1:0]                  rresp_reg;
  logic [31:0]                 rdata_reg;
  // output registers
  atapr_pkg::atapr_agc_s       agc_reg;
  atapr_pkg::atapr_path_s      path_ctl_reg;
  logic                        recover_reg;
  logic                        irq_reg;
  // dac power level arrives from another domain
  logic                        dacDownMeta_reg;
  logic                        dacDownSync_reg;

  // word index of each channel
  wire [atapr_pkg::IDX_W-1:0] wrIdx = s_axi_awaddr[atapr_pkg::ADDR_W-1:2];
  wire [atapr_pkg::IDX_W-1:0] rdIdx = s_axi_araddr[atapr_pkg::ADDR_W-1:2];

  // shared address decode for both channels
  function automatic logic isMapped(
    input logic [atapr_pkg::IDX_W-1:0] idx
  );
    isMapped = (idx == atapr_pkg::IDX_ATTACK)   ||
               (idx == atapr_pkg::IDX_DECAY)    ||
               (idx == atapr_pkg::IDX_PATH)     ||
               (idx == atapr_pkg::IDX_IRQ_STAT) ||
               (idx == atapr_pkg::IDX_IRQ_MASK) ||
               (idx == atapr_pkg::IDX_EFF_TIME);
  endfunction : isMapped

  // byte-lane merge for an 8-bit register
  // only lane zero carries data; the upper lanes are ignored,
  // so a write with wstrb[0] low leaves the register untouched
  function automatic logic [7:0] laneMerge(
    input logic [7:0] old,
    input logic [7:0] wmask
  );
    laneMerge = s_axi_wstrb[0] ? ((s_axi_wdata[7:0] & wmask) |
                                  (old & ~wmask)) : old;
  endfunction : laneMerge

  // handshakes; address and data are taken at the same edge
  wire wrTake = awready_reg & s_axi_awvalid;
  wire rdTake = arready_reg & s_axi_arvalid;
  wire wrOk   = wrTake & isMapped(wrIdx);
  wire wrAtk  = wrTake & (wrIdx == atapr_pkg::IDX_ATTACK);
  wire wrDec  = wrTake & (wrIdx == atapr_pkg::IDX_DECAY);
  wire wrPath = wrTake & (wrIdx == atapr_pkg::IDX_PATH);
  wire wrMask = wrTake & (wrIdx == atapr_pkg::IDX_IRQ_MASK);
  // reads with side effects
  wire rdPath = rdTake & (rdIdx == atapr_pkg::IDX_PATH);
  wire rdStat = rdTake & (rdIdx == atapr_pkg::IDX_IRQ_STAT);

  // effective time computation
  atapr_pkg::atapr_ms_t attackMs;
  atapr_pkg::atapr_ms_t decayMs;
  logic                 decayCapped;
  wire atapr_pkg::atapr_ms_t capMs =
    atapr_pkg::DECAY_CAP_MS[adcDecimationRatio];

  // attack: own fields or legacy, never capped
  atapr_time_calc #(
    .BASE_MS (atapr_pkg::ATTACK_BASE_MS)
  ) u_attack (
    .useOwn   (attack_reg[atapr_pkg::SRC_BIT]),
    .baseCode (attack_reg[atapr_pkg::BASE_HI:atapr_pkg::BASE_LO]),
    .multCode (attack_reg[atapr_pkg::MULT_HI:atapr_pkg::MULT_LO]),
    .legacyMs (legacyAttackMs),
    .capMs    (atapr_pkg::NO_CAP_MS),
    .timeMs   (attackMs),
    .capped   ()
  );

  // decay: own fields or legacy, limited by the ratio cap
  atapr_time_calc #(
    .BASE_MS (atapr_pkg::DECAY_BASE_MS)
  ) u_decay (
    .useOwn   (decay_reg[atapr_pkg::SRC_BIT]),
    .baseCode (decay_reg[atapr_pkg::BASE_HI:atapr_pkg::BASE_LO]),
    .multCode (decay_reg[atapr_pkg::MULT_HI:atapr_pkg::MULT_LO]),
    .legacyMs (legacyDecayMs),
    .capMs    (capMs),
    .timeMs   (decayMs),
    .capped   (decayCapped)
  );

  // detection is live only while the disable bit is clear
  wire busDetectOn = ~path_reg[atapr_pkg::BUSDIS_BIT];
  wire busErrEvent = busErrorSeen & busDetectOn;
  wire capEvent    = decayCapped & ~capPrev_reg;

  // new sticky events
  wire [atapr_pkg::IRQ_W-1:0] irqSet =
    {capEvent, busErrEvent};

  // path register read view, d1 always zero
  wire [7:0] pathView = {
    path_reg[atapr_pkg::HPF_L_BIT:atapr_pkg::BUSDIS_BIT],
    1'b0, busErr_reg};

  // read data multiplexer
  logic [31:0] rdMux;
  always_comb begin
    rdMux = 32'h0000_0000;
    unique case (rdIdx)
      atapr_pkg::IDX_ATTACK:   rdMux[7:0] = attack_reg;
      atapr_pkg::IDX_DECAY:    rdMux[7:0] = decay_reg;
      atapr_pkg::IDX_PATH:     rdMux[7:0] = pathView;
      atapr_pkg::IDX_IRQ_STAT:
        rdMux[atapr_pkg::IRQ_W-1:0] = irqStat_reg;
      atapr_pkg::IDX_IRQ_MASK:
        rdMux[atapr_pkg::IRQ_W-1:0] = irqMask_reg;
      atapr_pkg::IDX_EFF_TIME: rdMux = {decayMs, attackMs};
      default:                 rdMux = 32'h0000_0000;
    endcase
  end

  // two-flop synchroniser for the dac power level
  always_ff @(posedge clk) begin
    if (rst) begin
      dacDownMeta_reg <= 1'b0;
      dacDownSync_reg <= 1'b0;
    end else begin
      dacDownMeta_reg <= dacsPoweredDown;
      dacDownSync_reg <= dacDownMeta_reg;
    end
  end

  // write channel: one-cycle ready once both halves are offered
  // waiting for both halves costs a cycle but keeps one take edge
  always_ff @(posedge clk) begin
    if (rst) begin
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
    end else begin
      awready_reg <= ~awready_reg & ~bvalid_reg &
                     s_axi_awvalid & s_axi_wvalid;
      wready_reg  <= ~awready_reg & ~bvalid_reg &
                     s_axi_awvalid & s_axi_wvalid;
    end
  end

  // write response; unmapped words answer slverr
  always_ff @(posedge clk) begin
    if (rst) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= atapr_pkg::RESP_OKAY;
    end else if (wrTake) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= wrOk ? atapr_pkg::RESP_OKAY
                         : atapr_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // read channel: one-cycle ready, data one edge after taking
  always_ff @(posedge clk) begin
    if (rst) begin
      arready_reg <= 1'b0;
    end else begin
      arready_reg <= ~arready_reg & ~rvalid_reg & s_axi_arvalid;
    end
  end

  // read data capture; side effects happen at the same edge
  always_ff @(posedge clk) begin
    if (rst) begin
      rvalid_reg <= 1'b0;
      rresp_reg  <= atapr_pkg::RESP_OKAY;
      rdata_reg  <= 32'h0000_0000;
    end else if (rdTake) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= isMapped(rdIdx) ? atapr_pkg::RESP_OKAY
                                    : atapr_pkg::RESP_SLVERR;
      rdata_reg  <= rdMux;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // time registers; low reserved bits are stored as written,
  // the host is expected to keep them zero
  always_ff @(posedge clk) begin
    if (rst) begin
      attack_reg <= atapr_pkg::REG_RESET;
      decay_reg  <= atapr_pkg::REG_RESET;
    end else begin
      if (wrAtk) begin
        attack_reg <= laneMerge(attack_reg, 8'hFF);
      end
      if (wrDec) begin
        decay_reg <= laneMerge(decay_reg, 8'hFF);
      end
    end
  end

  // path register: only d7..d2 take writes
  always_ff @(posedge clk) begin
    if (rst) begin
      path_reg <= atapr_pkg::REG_RESET;
    end else if (wrPath) begin
      path_reg <= laneMerge(path_reg, atapr_pkg::PATH_WMASK);
    end
  end

  // bus error status: a new error wins over the clearing read
  always_ff @(posedge clk) begin
    if (rst) begin
      busErr_reg <= 1'b0;
    end else if (busErrEvent) begin
      busErr_reg <= 1'b1;
    end else if (rdPath) begin
      busErr_reg <= 1'b0;
    end
  end

  // interrupt status and mask; set wins over read-clear
  always_ff @(posedge clk) begin
    if (rst) begin
      irqStat_reg <= '0;
      irqMask_reg <= '0;
      capPrev_reg <= 1'b0;
    end else begin
      irqStat_reg <= (rdStat ? '0 : irqStat_reg) | irqSet;
      capPrev_reg <= decayCapped;
      if (wrMask && s_axi_wstrb[0]) begin
        irqMask_reg <= s_axi_wdata[atapr_pkg::IRQ_W-1:0];
      end
    end
  end

  // applied times, registered so outputs never glitch
  always_ff @(posedge clk) begin
    if (rst) begin
      agc_reg <= '0;
    end else begin
      agc_reg.attackMs <= attackMs;
      agc_reg.decayMs  <= decayMs;
    end
  end

  // path steering outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      path_ctl_reg <= '0;
    end else begin
      path_ctl_reg.hpfProgLeft    <= path_reg[atapr_pkg::HPF_L_BIT];
      path_ctl_reg.hpfProgRight   <= path_reg[atapr_pkg::HPF_R_BIT];
      path_ctl_reg.micAnalogLeft  <= path_reg[atapr_pkg::MIC_L_BIT];
      path_ctl_reg.micAnalogRight <= path_reg[atapr_pkg::MIC_R_BIT];
      // filter joins the adc only while both dacs are down
      path_ctl_reg.progFilterOn   <= path_reg[atapr_pkg::PFILT_BIT] &
                                     dacDownSync_reg;
      path_ctl_reg.busDetectOn    <= busDetectOn;
    end
  end

  // self-clearing of the bus condition, and the interrupt line
  always_ff @(posedge clk) begin
    if (rst) begin
      recover_reg <= 1'b0;
      irq_reg     <= 1'b0;
    end else begin
      recover_reg <= busErrEvent;
      irq_reg     <= |(irqStat_reg & irqMask_reg);
    end
  end

  // every output straight from a flip-flop
  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;
  assign agcTimes      = agc_reg;
  assign pathCtrl      = path_ctl_reg;
  assign busErrRecover = recover_reg;
  assign irq           = irq_reg;
endmodule : atapr_regs

/* test/atapr_side_model.sv */
`timescale 1ns/10ps
// stands in for the older timing register and the bus error detector
module atapr_side_model #(
  parameter atapr_pkg::atapr_ms_t ATT_MS = 16'h0123, // older attack time
  parameter atapr_pkg::atapr_ms_t DEC_MS = 16'h0FFF  // above ratio one cap
) (
  input  logic                 clk,
  input  logic                 rst,
  input  logic                 errFire,
  output atapr_pkg::atapr_ms_t legacyAttackMs,
  output atapr_pkg::atapr_ms_t legacyDecayMs,
  output logic                 busErrorSeen
);
  logic fireLast_reg; // last seen request level
  // fixed times, the older register is not exercised here
  assign legacyAttackMs = ATT_MS;
  assign legacyDecayMs  = DEC_MS;
  // each toggle of errFire gives one error pulse, never a level
  always_ff @(posedge clk) begin
    if (rst) begin
      fireLast_reg <= 1'h0;
      busErrorSeen <= 1'h0;
    end else begin
      fireLast_reg <= errFire;
      busErrorSeen <= errFire ^ fireLast_reg;
    end
  end
endmodule : atapr_side_model

/* test/atapr_properties.sv */
`timescale 1ns/10ps
// handshake and gain control output checks
module atapr_properties (
  input logic                  clk,
  input logic                  rst,
  input logic                  s_axi_awvalid,
  input logic                  s_axi_awready,
  input logic                  s_axi_wvalid,
  input logic                  s_axi_wready,
  input logic                  s_axi_bvalid,
  input logic                  s_axi_bready,
  input logic                  s_axi_arvalid,
  input logic                  s_axi_arready,
  input logic                  s_axi_rvalid,
  input logic                  s_axi_rready,
  input logic [31:0]           s_axi_rdata,
  input logic [3:0]            adcDecimationRatio,
  input logic                  dacsPoweredDown,
  input logic                  busErrorSeen,
  input atapr_pkg::atapr_agc_s agcTimes,
  input atapr_pkg::atapr_path_s pathCtrl,
  input logic                  busErrRecover
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // the two transfer starts
  sequence s_wtake;
    s_axi_awvalid && s_axi_awready;
  endsequence
  sequence s_rtake;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_wr_pair;
    s_axi_awready == s_axi_wready;
  endproperty
  a_wr_pair: assert property (p_wr_pair) else $error("write ready split");
  property p_wr_resp;
    s_wtake |=> s_axi_bvalid;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("no write response");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
  property p_rd_resp;
    s_rtake |=> s_axi_rvalid;
  endproperty
  a_rd_resp: assert property (p_rd_resp) else $error("no read data");
  property p_ar_pulse;
    s_axi_arready |=> !s_axi_arready;
  endproperty
  a_ar_pulse: assert property (p_ar_pulse) else $error("arready too long");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data moved");
  // decay never above the cap of the ratio seen one edge before
  property p_cap;
    agcTimes.decayMs <= atapr_pkg::DECAY_CAP_MS[$past(adcDecimationRatio)];
  endproperty
  a_cap: assert property (p_cap) else $error("decay above cap");
  property p_recover;
    busErrRecover |-> $past(busErrorSeen);
  endproperty
  a_recover: assert property (p_recover) else $error("stray recover");
  // lag is two to three cycles, four lows leave no doubt
  property p_prog;
    !dacsPoweredDown [*4] |=> !pathCtrl.progFilterOn;
  endproperty
  a_prog: assert property (p_prog) else $error("filter with dacs up");
endmodule : atapr_properties

/* test/testbench.sv */
`timescale 1ns/10ps
// register bank bench driven over the register bus
module testbench;
  logic        clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_arready, s_axi_rvalid, s_axi_rready, irq;
  logic        dacsPoweredDown, busErrorSeen, busErrRecover, errFire;
  logic [9:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb, adcDecimationRatio;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [15:0] e;        // expected time
  int          failures, n_checks, i;
  int          nRecover; // self-clear pulses seen
  atapr_pkg::atapr_ms_t   legacyAttackMs, legacyDecayMs;
  atapr_pkg::atapr_agc_s  agcTimes;
  atapr_pkg::atapr_path_s pathCtrl;
  // far side: older timing register and bus error source
  atapr_side_model SIDE (.clk, .rst, .errFire, .legacyAttackMs,
    .legacyDecayMs, .busErrorSeen);
  atapr_regs DUT (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .legacyAttackMs,
    .legacyDecayMs, .adcDecimationRatio, .dacsPoweredDown, .busErrorSeen,
    .agcTimes, .pathCtrl, .busErrRecover, .irq);
  // 50 MHz clock
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  // count recover pulses, an accepted error must give exactly one
  always @(posedge clk) begin
    if (rst) begin
      nRecover <= 0;
    end else if (busErrRecover) begin
      nRecover <= nRecover + 1;
    end
  end
  // verdict, reached from the end or from a timeout
  task automatic tally_and_finish;
    if (failures == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask : tick
  // write; bready only after bvalid, so the slave must hold it
  task automatic wr(input logic [7:0] idx, input logic [7:0] d,
                    input logic [1:0] er);
    int n;
    s_axi_awaddr  <= {idx, 2'h0};
    s_axi_wdata   <= {24'h0, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid  <= 1'h1;
    for (n = 0; n < 64; n++) begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid && s_axi_bready) break;
      if (s_axi_bvalid) s_axi_bready <= 1'h1;
    end
    s_axi_bready <= 1'h0;
    if (n == 64) begin
      failures++;
      tally_and_finish();
    end
    check({30'h0, s_axi_bresp}, {30'h0, er});
  endtask : wr
  // read; rready likewise late
  task automatic rd(input logic [7:0] idx, input logic [31:0] exp,
                    input logic [1:0] er);
    int n;
    s_axi_araddr  <= {idx, 2'h0};
    s_axi_arvalid <= 1'h1;
    for (n = 0; n < 64; n++) begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid && s_axi_rready) break;
      if (s_axi_rvalid) s_axi_rready <= 1'h1;
    end
    s_axi_rready <= 1'h0;
    if (n == 64) begin
      failures++;
      tally_and_finish();
    end
    check(s_axi_rdata, exp);
    check({30'h0, s_axi_rresp}, {30'h0, er});
  endtask : rd
  // main sequence
  initial begin
    failures = 0;
    n_checks = 0;
    rst <= 1'h1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h0;
    {s_axi_arvalid, s_axi_rready, dacsPoweredDown, errFire} <= 4'h0;
    s_axi_awaddr <= 10'h0;
    s_axi_araddr <= 10'h0;
    s_axi_wdata <= 32'h0;
    s_axi_wstrb <= 4'h1;
    adcDecimationRatio <= 4'h0;
    tick(16);
    rst <= 1'h0;
    tick(3);
    check(agcTimes, {16'h0123, 16'h0FA0});
    rd(atapr_pkg::IDX_ATTACK, 32'h0, atapr_pkg::RESP_OKAY);
    rd(atapr_pkg::IDX_DECAY, 32'h0, atapr_pkg::RESP_OKAY);
    rd(atapr_pkg::IDX_PATH, 32'h0, atapr_pkg::RESP_OKAY);
    // every attack base and multiplier, low bits kept zero
    for (i = 0; i < 32; i++) begin
      wr(atapr_pkg::IDX_ATTACK, {1'h1, i[4:0], 2'h0}, 2'h0);
      tick(3);
      e = atapr_pkg::ATTACK_BASE_MS[i[4:3]] << i[2:0];
      check({16'h0, agcTimes.attackMs}, {16'h0, e});
    end
    rd(atapr_pkg::IDX_ATTACK, 32'hFC, atapr_pkg::RESP_OKAY);
    // every decay setting under the largest cap
    adcDecimationRatio <= 4'hF;
    for (i = 0; i < 32; i++) begin
      wr(atapr_pkg::IDX_DECAY, {1'h1, i[4:0], 2'h0}, 2'h0);
      tick(3);
      e = atapr_pkg::DECAY_BASE_MS[i[4:3]] << i[2:0];
      if (e > atapr_pkg::DECAY_CAP_MS[15]) e = atapr_pkg::DECAY_CAP_MS[15];
      check({16'h0, agcTimes.decayMs}, {16'h0, e});
    end
    // longest decay against each ratio code
    for (i = 0; i < 16; i++) begin
      adcDecimationRatio <= i[3:0];
      tick(3);
      e = atapr_pkg::DECAY_CAP_MS[i];
      check({16'h0, agcTimes.decayMs}, {16'h0, e});
    end
    wr(atapr_pkg::IDX_DECAY, 8'h7C, 2'h0);
    tick(3);
    check({16'h0, agcTimes.decayMs}, 32'h0FFF);
    // high-pass selects and microphone codes together
    for (i = 0; i < 4; i++) begin
      wr(atapr_pkg::IDX_PATH, {i[0], i[1], i[1:0], 4'h0}, 2'h0);
      tick(3);
      check({26'h0, pathCtrl}, {26'h0, i[0], i[1], i[1:0], 2'h1});
      rd(atapr_pkg::IDX_PATH, {24'h0, i[0], i[1], i[1:0], 4'h0}, 2'h0);
    end
    // filter only with both dacs down
    wr(atapr_pkg::IDX_PATH, 8'h08, 2'h0);
    tick(6);
    check({31'h0, pathCtrl.progFilterOn}, 32'h0);
    dacsPoweredDown <= 1'h1;
    tick(6);
    check({31'h0, pathCtrl.progFilterOn}, 32'h1);
    dacsPoweredDown <= 1'h0;
    // cap events above left bit one set; clear it
    rd(atapr_pkg::IDX_IRQ_STAT, 32'h2, 2'h0);
    rd(atapr_pkg::IDX_IRQ_STAT, 32'h0, 2'h0);
    errFire <= 1'h1;
    tick(3);
    check({31'h0, irq}, 32'h0);
    wr(atapr_pkg::IDX_IRQ_MASK, 8'h01, 2'h0);
    tick(3);
    check({31'h0, irq}, 32'h1);
    rd(atapr_pkg::IDX_PATH, 32'h9, 2'h0);
    rd(atapr_pkg::IDX_PATH, 32'h8, 2'h0);
    check(nRecover, 32'h1);
    rd(atapr_pkg::IDX_IRQ_STAT, 32'h1, 2'h0);
    tick(3);
    check({31'h0, irq}, 32'h0);
    // detection off: error ignored
    wr(atapr_pkg::IDX_PATH, 8'h04, 2'h0);
    errFire <= 1'h0;
    tick(3);
    rd(atapr_pkg::IDX_PATH, 32'h4, 2'h0);
    rd(atapr_pkg::IDX_IRQ_STAT, 32'h0, 2'h0);
    check(nRecover, 32'h1);
    // unmapped place answers with an error
    wr(8'h00, 8'h55, atapr_pkg::RESP_SLVERR);
    rd(8'h00, 32'h0, atapr_pkg::RESP_SLVERR);
    // a write with lane zero off changes nothing
    s_axi_wstrb <= 4'h0;
    wr(atapr_pkg::IDX_IRQ_MASK, 8'h00, 2'h0);
    s_axi_wstrb <= 4'h1;
    rd(atapr_pkg::IDX_IRQ_MASK, 32'h1, 2'h0);
    // applied times: legacy decay below cap, 11 ms times 128 attack
    rd(atapr_pkg::IDX_EFF_TIME, 32'h0FFF_0580, 2'h0);
    tally_and_finish();
  end
endmodule : testbench
bind atapr_regs atapr_properties u_props (.clk, .rst, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .adcDecimationRatio, .dacsPoweredDown,
  .busErrorSeen, .agcTimes, .pathCtrl, .busErrRecover);
